// ==== logic/safe_io_expansion.sv ====
/*
  safe i/o expansion unit: eight safe inputs forwarded over the expansion bus,
  four safe outputs switched on controller command, two test pulse generators,
  local fast shut-off and cross-circuit monitoring of the outputs.
  assumes a main controller end on the bus, a read-back level per output, and
  inputs synchronous to core_clk.
*/
`timescale 1ns/1ps
module safe_io_expansion #(
  parameter int unsigned DEADLINE_STD = safe_io_pkg::DEADLINE_STD_CYC,
  parameter int unsigned DEADLINE_EXT = safe_io_pkg::DEADLINE_EXT_CYC,
  parameter int unsigned TP_PERIOD = safe_io_pkg::TEST_PERIOD_CYC,
  parameter int unsigned TP_GAP = safe_io_pkg::TEST_GAP_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // expansion bus
  expansion_bus_if.dev bus,
  // field side inputs
  input wire logic [safe_io_pkg::NUM_INPUTS-1:0] safe_input_channel,
  input wire logic [safe_io_pkg::NUM_OUTPUTS-1:0] output_readback,
  // field side outputs
  output logic [safe_io_pkg::NUM_OUTPUTS-1:0] safe_output_channel,
  output logic first_test_pulse_output,
  output logic second_test_pulse_output,
  output logic module_state_indicator
);
  import safe_io_pkg::*;

  // ****************************************
  // types and helpers
  // ****************************************
  typedef enum logic [1:0] {
    ST_WAIT_CFG = 2'b01,
    ST_RUN = 2'b10
  } dev_state_t;

  // test gap sits at the start of each period
  function automatic logic in_gap(input logic [CNT_W-1:0] cnt);
    in_gap = (cnt < CNT_W'(TP_GAP));
  endfunction : in_gap

  // next count of a wrapping period counter
  function automatic logic [CNT_W-1:0] wrap_inc(input logic [CNT_W-1:0] cnt);
    wrap_inc = (cnt >= CNT_W'(TP_PERIOD - 1)) ? '0 : cnt + CNT_W'(1);
  endfunction : wrap_inc

  dev_state_t state_reg;
  logic [NUM_OUTPUTS-1:0] tp_disable_reg;
  logic ext_detect_reg;
  logic [NUM_OUTPUTS-1:0] fast_shutoff_reg;
  logic [NUM_OUTPUTS-1:0] cmd_reg;
  logic [NUM_OUTPUTS-1:0] fault_reg;
  logic [NUM_OUTPUTS-1:0] fault_next;
  logic [NUM_OUTPUTS-1:0] drive_next;
  logic [NUM_OUTPUTS-1:0] prev_out_reg;
  logic [CNT_W-1:0] tp_cnt_reg [NUM_TEST_GENS];
  logic [NUM_TEST_GENS-1:0] gap;
  logic [CNT_W-1:0] mon_cnt_reg [NUM_OUTPUTS];
  logic [CNT_W-1:0] deadline;
  logic running;

  assign running = (state_reg == ST_RUN) && bus.link_alive;

  // ****************************************
  // start-up configuration
  // ****************************************
  // nothing is kept locally across reset: settings come from the plug image
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= ST_WAIT_CFG;
    end else begin
      unique case (state_reg)
        ST_WAIT_CFG: begin
          if (bus.cfg_load) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN; // frozen until the next reset
        end
      endcase
    end
  end

  // settings captured once; ignored later so they cannot change while running
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tp_disable_reg <= '0;
      ext_detect_reg <= 1'b0;
      fast_shutoff_reg <= '0;
    end else if (state_reg == ST_WAIT_CFG && bus.cfg_load) begin
      tp_disable_reg <= bus.cfg_tp_disable;
      ext_detect_reg <= bus.cfg_ext_detect;
      fast_shutoff_reg <= bus.cfg_fast_shutoff;
    end
  end

  // ****************************************
  // controller commands
  // ****************************************
  // last command kept; dropped when the controller goes away
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cmd_reg <= OUT_RESET;
    end else if (!running) begin
      cmd_reg <= OUT_RESET;
    end else if (bus.cmd_valid) begin
      cmd_reg <= bus.out_cmd;
    end
  end

  // ****************************************
  // test pulse generators
  // ****************************************
  // second generator runs half a period behind so the gaps never overlap
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tp_cnt_reg[0] <= '0;
      tp_cnt_reg[1] <= CNT_W'(TP_PERIOD / 2);
    end else begin
      tp_cnt_reg[0] <= wrap_inc(tp_cnt_reg[0]);
      tp_cnt_reg[1] <= wrap_inc(tp_cnt_reg[1]);
    end
  end

  assign gap[0] = in_gap(tp_cnt_reg[0]);
  assign gap[1] = in_gap(tp_cnt_reg[1]);

  // test outputs are high outside their gaps
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      first_test_pulse_output <= 1'b0;
      second_test_pulse_output <= 1'b0;
    end else begin
      first_test_pulse_output <= ~gap[0];
      second_test_pulse_output <= ~gap[1];
    end
  end

  // ****************************************
  // output drive
  // ****************************************
  // local shut-off acts within one cycle, far inside the added 8 ms allowance
  always_comb begin
    for (int j = 0; j < NUM_OUTPUTS; j++) begin
      drive_next[j] = running && cmd_reg[j] && !fault_next[j];
      if (fast_shutoff_reg[j] && !safe_input_channel[j]) begin
        drive_next[j] = 1'b0;
      end
      // an untested output stays high, so a short to supply goes unseen
      if (!tp_disable_reg[j] && gap[j % NUM_TEST_GENS]) begin
        drive_next[j] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      safe_output_channel <= OUT_RESET;
      prev_out_reg <= OUT_RESET;
    end else begin
      safe_output_channel <= drive_next;
      prev_out_reg <= safe_output_channel;
    end
  end

  // ****************************************
  // cross-circuit monitor
  // ****************************************
  assign deadline = ext_detect_reg ? CNT_W'(DEADLINE_EXT) : CNT_W'(DEADLINE_STD);

  // counts cycles of read-back disagreeing with the driven level;
  // restarts on every edge of the driven level so the deadline runs from it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int j = 0; j < NUM_OUTPUTS; j++) begin
        mon_cnt_reg[j] <= '0;
      end
    end else begin
      for (int j = 0; j < NUM_OUTPUTS; j++) begin
        if (safe_output_channel[j] != prev_out_reg[j]) begin
          mon_cnt_reg[j] <= '0;
        end else if (output_readback[j] == safe_output_channel[j]) begin
          mon_cnt_reg[j] <= '0;
        end else if (mon_cnt_reg[j] < deadline) begin
          mon_cnt_reg[j] <= mon_cnt_reg[j] + CNT_W'(1);
        end
      end
    end
  end

  // fault once the deadline is used up with the mismatch still present,
  // regardless of the output's test pulse setting
  always_comb begin
    for (int j = 0; j < NUM_OUTPUTS; j++) begin
      fault_next[j] = fault_reg[j] ||
        (mon_cnt_reg[j] >= deadline && output_readback[j] != safe_output_channel[j]);
    end
  end

  // sticky until reset; the forced-low output falls on the same edge as fault_reg sets,
  // well inside the 10 ms / 50 ms reaction budget
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fault_reg <= '0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // ****************************************
  // reports to the controller
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bus.in_state <= IN_RESET;
      bus.out_fault <= '0;
      bus.dev_running <= 1'b0;
      module_state_indicator <= 1'b0;
    end else begin
      bus.in_state <= safe_input_channel;
      bus.out_fault <= fault_reg;
      bus.dev_running <= running;
      module_state_indicator <= running && (fault_reg == '0);
    end
  end

endmodule : safe_io_expansion

// ==== logic/safe_io_pkg.sv ====
/*
  constants shared by the safe i/o expansion unit and its main controller end:
  channel counts, timing figures and the cycle counts derived from them.
  assumes a single 200 MHz core clock on both ends.
*/
package safe_io_pkg;

  // ****************************************
  // channel counts
  // ****************************************
  localparam int NUM_INPUTS = 8;
  localparam int NUM_OUTPUTS = 4;
  localparam int NUM_TEST_GENS = 2;

  // ****************************************
  // clock and timing figures
  // ****************************************
  localparam int unsigned CLK_FREQ_MHZ = 200;
  localparam int unsigned FAST_SHUTOFF_US = 8000;      // longest added local response
  localparam int unsigned LOW_DEADLINE_STD_US = 3000;  // standard low-level deadline
  localparam int unsigned LOW_DEADLINE_EXT_US = 43000; // extended low-level deadline
  localparam int unsigned FAULT_REACT_STD_US = 10000;  // detection plus reaction, standard
  localparam int unsigned FAULT_REACT_EXT_US = 50000;  // detection plus reaction, extended
  localparam int unsigned TEST_GAP_US = 4000;          // longest test gap
  localparam int unsigned TEST_PERIOD_US = 200000;     // shortest test period
  localparam int unsigned PROOF_LOW_US = 1000000;      // least all-low proof time

  // ****************************************
  // derived cycle counts
  // ****************************************
  localparam int unsigned FAST_SHUTOFF_CYC = FAST_SHUTOFF_US * CLK_FREQ_MHZ;
  localparam int unsigned DEADLINE_STD_CYC = LOW_DEADLINE_STD_US * CLK_FREQ_MHZ;
  localparam int unsigned DEADLINE_EXT_CYC = LOW_DEADLINE_EXT_US * CLK_FREQ_MHZ;
  localparam int unsigned FAULT_REACT_STD_CYC = FAULT_REACT_STD_US * CLK_FREQ_MHZ;
  localparam int unsigned FAULT_REACT_EXT_CYC = FAULT_REACT_EXT_US * CLK_FREQ_MHZ;
  localparam int unsigned TEST_GAP_CYC = TEST_GAP_US * CLK_FREQ_MHZ;
  localparam int unsigned TEST_PERIOD_CYC = TEST_PERIOD_US * CLK_FREQ_MHZ;
  localparam int unsigned PROOF_LOW_CYC = PROOF_LOW_US * CLK_FREQ_MHZ;

  // counters wide enough for the one-second proof time
  localparam int CNT_W = 28;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [NUM_OUTPUTS-1:0] OUT_RESET = 4'h0;
  localparam logic [NUM_INPUTS-1:0] IN_RESET = 8'h00;

endpackage : safe_io_pkg

// ==== logic/expansion_bus_if.sv ====
/*
  internal expansion bus between the main controller and the safe i/o unit.
  assumes both ends run on the same core clock; no clocking block.
*/
`timescale 1ns/1ps
interface expansion_bus_if;
  import safe_io_pkg::*;

  // device to controller
  logic [NUM_INPUTS-1:0] in_state;
  logic [NUM_OUTPUTS-1:0] out_fault;
  logic dev_running;
  // controller to device
  logic link_alive;
  logic cfg_load;
  logic [NUM_OUTPUTS-1:0] cfg_tp_disable;
  logic cfg_ext_detect;
  logic [NUM_OUTPUTS-1:0] cfg_fast_shutoff;
  logic cmd_valid;
  logic [NUM_OUTPUTS-1:0] out_cmd;

  modport dev (
    output in_state, out_fault, dev_running,
    input link_alive, cfg_load, cfg_tp_disable, cfg_ext_detect, cfg_fast_shutoff,
    input cmd_valid, out_cmd
  );

  modport ctrl (
    input in_state, out_fault, dev_running,
    output link_alive, cfg_load, cfg_tp_disable, cfg_ext_detect, cfg_fast_shutoff,
    output cmd_valid, out_cmd
  );
endinterface : expansion_bus_if

// ==== logic/expansion_controller.sv ====
/*
  main controller end of the expansion bus: holds the plug image, loads it
  into the unit at start, sends output commands and runs the all-low proof.
  assumes the same core clock as the unit; the plug image is never reset.
*/
`timescale 1ns/1ps
module expansion_controller #(
  parameter int unsigned PROOF_LOW = safe_io_pkg::PROOF_LOW_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // expansion bus
  expansion_bus_if.ctrl bus,
  // plug write port
  input wire logic plug_wr,
  input wire logic [safe_io_pkg::NUM_OUTPUTS-1:0] plug_tp_disable,
  input wire logic plug_ext_detect,
  input wire logic [safe_io_pkg::NUM_OUTPUTS-1:0] plug_fast_shutoff,
  input wire logic [safe_io_pkg::NUM_OUTPUTS-1:0] plug_cap_mask,
  // user control
  input wire logic start,
  input wire logic [safe_io_pkg::NUM_OUTPUTS-1:0] out_request,
  input wire logic proof_test_req,
  // user status
  output logic [safe_io_pkg::NUM_INPUTS-1:0] input_view,
  output logic [safe_io_pkg::NUM_OUTPUTS-1:0] fault_view,
  output logic proof_active
);
  import safe_io_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } ctrl_state_t;

  ctrl_state_t state_reg;
  logic [NUM_OUTPUTS-1:0] plug_tp_dis_reg;
  logic plug_ext_reg;
  logic [NUM_OUTPUTS-1:0] plug_fast_reg;
  logic [CNT_W-1:0] proof_cnt_reg;

  // ****************************************
  // plug image
  // ****************************************
  // non-volatile store: no reset, so contents outlive a supply loss
  always_ff @(posedge core_clk) begin
    if (plug_wr) begin
      plug_tp_dis_reg <= plug_tp_disable | (plug_ext_detect ? plug_cap_mask : '0);
      plug_ext_reg <= plug_ext_detect;
      plug_fast_reg <= plug_fast_shutoff;
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // proof run of untested outputs
  // ****************************************
  // yearly scheduling is left to the user; a request restarts the hold
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      proof_cnt_reg <= '0;
    end else if (proof_test_req && state_reg == ST_RUN) begin
      proof_cnt_reg <= CNT_W'(PROOF_LOW);
    end else if (proof_cnt_reg != '0) begin
      proof_cnt_reg <= proof_cnt_reg - CNT_W'(1);
    end
  end

  // ****************************************
  // bus drive
  // ****************************************
  // commands are resent every running cycle, so a lost one heals itself
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bus.link_alive <= 1'b0;
      bus.cfg_load <= 1'b0;
      bus.cfg_tp_disable <= '0;
      bus.cfg_ext_detect <= 1'b0;
      bus.cfg_fast_shutoff <= '0;
      bus.cmd_valid <= 1'b0;
      bus.out_cmd <= OUT_RESET;
    end else begin
      bus.link_alive <= (state_reg != ST_IDLE);
      bus.cfg_load <= (state_reg == ST_LOAD);
      bus.cfg_tp_disable <= plug_tp_dis_reg;
      bus.cfg_ext_detect <= plug_ext_reg;
      bus.cfg_fast_shutoff <= plug_fast_reg;
      bus.cmd_valid <= (state_reg == ST_RUN);
      bus.out_cmd <= out_request & ~((proof_cnt_reg != '0) ? plug_tp_dis_reg : '0);
    end
  end

  // ****************************************
  // user status
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      input_view <= IN_RESET;
      fault_view <= '0;
      proof_active <= 1'b0;
    end else begin
      input_view <= bus.in_state;
      fault_view <= bus.out_fault;
      proof_active <= (proof_cnt_reg != '0);
    end
  end

endmodule : expansion_controller

// ==== verification/safe_io_bus_properties.sv ====
/*
  concurrent checks on the expansion bus between the controller and the unit.
  assumes it sits beside the bus interface, on the single core clock.
*/
`timescale 1ns/1ps
module safe_io_bus_checker #(
  parameter int unsigned DEADLINE_STD = 20
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // device to controller
  input wire logic [safe_io_pkg::NUM_INPUTS-1:0] in_state,
  input wire logic [safe_io_pkg::NUM_OUTPUTS-1:0] out_fault,
  input wire logic dev_running,
  // controller to device
  input wire logic link_alive,
  input wire logic cfg_load,
  input wire logic [safe_io_pkg::NUM_OUTPUTS-1:0] cfg_tp_disable,
  input wire logic cfg_ext_detect,
  input wire logic [safe_io_pkg::NUM_OUTPUTS-1:0] cfg_fast_shutoff,
  input wire logic cmd_valid,
  input wire logic [safe_io_pkg::NUM_OUTPUTS-1:0] out_cmd
);
  import safe_io_pkg::*;

  // ****************************************
  // bus properties
  // ****************************************
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_cfg_to_run: assert property (cfg_load && link_alive |-> ##2 dev_running)
    else $error("unit not running two cycles after configuration");
  a_cfg_pulse: assert property (cfg_load |=> !cfg_load)
    else $error("configuration load longer than one cycle");
  a_cfg_once: assert property (dev_running |-> !cfg_load)
    else $error("configuration load while running");
  a_cfg_frozen: assert property (dev_running && $past(dev_running) |->
    $stable(cfg_tp_disable) && $stable(cfg_ext_detect) && $stable(cfg_fast_shutoff))
    else $error("configuration changed while running");
  a_link_first: assert property (!link_alive |=> !dev_running)
    else $error("unit running without a controller");
  a_cmd_in_run: assert property (dev_running |-> cmd_valid)
    else $error("no command while running");
  a_cmd_link: assert property (cmd_valid |-> link_alive)
    else $error("command without live link");
  a_fault_sticky: assert property (|out_fault |=>
    ((out_fault & $past(out_fault)) == $past(out_fault)))
    else $error("fault flag cleared without reset");
  // a fault needs the unit to have been running one deadline's worth of cycles earlier
  a_fault_late: assert property ($rose(|out_fault) |-> $past(dev_running, DEADLINE_STD))
    else $error("fault raised before the low deadline");
endmodule : safe_io_bus_checker

// ==== verification/safe_io_output_test_monitor_tb.sv ====
/*
  self-checking bench: controller and unit joined by the bus interface.
  assumes shortened timing parameters and a readback that follows each
  output one cycle late unless held high on purpose.
*/
`timescale 1ns/1ps
`define CMP(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module safe_io_output_test_monitor_tb;
  import safe_io_pkg::*;

  // ****************************************
  // stimulus and observation
  // ****************************************
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic plug_wr = 1'b0;
  logic [NUM_OUTPUTS-1:0] plug_tp_disable = 4'h0;
  logic plug_ext_detect = 1'b0;
  logic [NUM_OUTPUTS-1:0] plug_fast_shutoff = 4'h0;
  logic [NUM_OUTPUTS-1:0] plug_cap_mask = 4'h0;
  logic start = 1'b0;
  logic [NUM_OUTPUTS-1:0] out_request = 4'h0;
  logic proof_test_req = 1'b0;
  logic [NUM_INPUTS-1:0] safe_input_channel = 8'hff;
  logic [NUM_OUTPUTS-1:0] output_readback = 4'h0;
  logic [NUM_OUTPUTS-1:0] stuck = 4'h0; // readback held high, a short to supply
  logic [NUM_OUTPUTS-1:0] flt = 4'h0;
  logic [NUM_INPUTS-1:0] input_view;
  logic [NUM_OUTPUTS-1:0] fault_view;
  logic proof_active;
  logic [NUM_OUTPUTS-1:0] safe_output_channel;
  logic first_test_pulse_output;
  logic second_test_pulse_output;
  logic module_state_indicator;
  logic [19:0] q[$];
  logic [19:0] e;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 65865;
  event obs_ev;
  wire [19:0] obs = {input_view, fault_view, safe_output_channel, first_test_pulse_output,
    second_test_pulse_output, module_state_indicator, proof_active};

  always #2.5 core_clk = ~core_clk;

  // field readback lags the output by one cycle, well inside the deadline
  always @(posedge core_clk) output_readback <= safe_output_channel | stuck;

  expansion_bus_if expansion_bus_if_i ();
  safe_io_expansion #(.DEADLINE_STD(20), .DEADLINE_EXT(60), .TP_PERIOD(200), .TP_GAP(10))
    safe_io_expansion_i (.core_clk, .rst_b, .bus(expansion_bus_if_i), .safe_input_channel,
    .output_readback, .safe_output_channel, .first_test_pulse_output,
    .second_test_pulse_output, .module_state_indicator);
  expansion_controller #(.PROOF_LOW(50)) expansion_controller_i (.core_clk, .rst_b,
    .bus(expansion_bus_if_i), .plug_wr, .plug_tp_disable, .plug_ext_detect,
    .plug_fast_shutoff, .plug_cap_mask, .start, .out_request, .proof_test_req,
    .input_view, .fault_view, .proof_active);
  // the checker's default deadline already equals the shortened one given above
  safe_io_bus_checker safe_io_bus_checker_i (.core_clk, .rst_b,
    .in_state(expansion_bus_if_i.in_state), .out_fault(expansion_bus_if_i.out_fault),
    .dev_running(expansion_bus_if_i.dev_running), .link_alive(expansion_bus_if_i.link_alive),
    .cfg_load(expansion_bus_if_i.cfg_load), .cfg_tp_disable(expansion_bus_if_i.cfg_tp_disable),
    .cfg_ext_detect(expansion_bus_if_i.cfg_ext_detect),
    .cfg_fast_shutoff(expansion_bus_if_i.cfg_fast_shutoff),
    .cmd_valid(expansion_bus_if_i.cmd_valid), .out_cmd(expansion_bus_if_i.out_cmd));

  // ****************************************
  // tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // note the expected view, then let the watcher compare once settled
  task automatic chk(input logic [3:0] o, input logic [1:0] tp, input logic ms, input logic pa);
    q.push_back({safe_input_channel, flt, o, tp, ms, pa});
    #1;
    -> obs_ev;
    @(posedge core_clk);
  endtask : chk

  // checks run just after a gap ends, so no test gap hits them
  task automatic sync();
    @(posedge first_test_pulse_output);
    cyc(2);
  endtask : sync

  task automatic boot(input logic wr, input logic [3:0] tpd, input logic ext,
    input logic [3:0] fs, input logic [3:0] cap);
    rst_b <= 1'b0;
    stuck <= 4'h0;
    out_request <= 4'h0;
    safe_input_channel <= 8'hff;
    cyc(5);
    rst_b <= 1'b1;
    plug_wr <= wr;
    plug_tp_disable <= tpd;
    plug_ext_detect <= ext;
    plug_fast_shutoff <= fs;
    plug_cap_mask <= cap;
    cyc(1);
    plug_wr <= 1'b0;
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    flt = 4'h0;
    sync();
  endtask : boot

  // all outputs on, looked at inside a gap of the first generator
  task automatic gap_chk(input logic [3:0] o);
    out_request <= 4'hf;
    @(negedge first_test_pulse_output);
    cyc(3);
    chk(o, 2'b01, 1'b1, 1'b0);
  endtask : gap_chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // watcher, watchdog and main sequence
  // ****************************************
  always @(obs_ev) begin
    e = q.pop_front();
    `CMP(obs, e)
  end

  // whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    test_done();
  end

  initial begin
    // outputs 1 and 3 untested, outputs 1 and 2 shut locally by inputs 1 and 2
    boot(1'b1, 4'b1010, 1'b0, 4'b0110, 4'b0001);
    for (int i = 0; i < 6; i++) begin
      safe_input_channel <= 8'($random(seed));
      out_request <= 4'($random(seed));
      cyc(5);
      chk(out_request & ~(plug_fast_shutoff & ~safe_input_channel[3:0]), 2'b11, 1'b1, 1'b0);
    end
    safe_input_channel <= 8'hff;
    gap_chk(4'b1010);
    // last cycle of the gap, then the first cycle after it: gap is exactly TP_GAP long
    cyc(5);
    chk(4'b1010, 2'b01, 1'b1, 1'b0);
    chk(4'hf, 2'b11, 1'b1, 1'b0);
    sync();
    chk(4'hf, 2'b11, 1'b1, 1'b0);
    proof_test_req <= 1'b1;
    cyc(1);
    proof_test_req <= 1'b0;
    cyc(4);
    chk(4'b0101, 2'b11, 1'b1, 1'b1);
    cyc(50);
    chk(4'hf, 2'b11, 1'b1, 1'b0);
    sync();
    stuck <= 4'b0010;
    out_request <= 4'b1101;
    cyc(15);
    chk(4'b1101, 2'b11, 1'b1, 1'b0);
    cyc(20);
    flt = 4'b0010;
    chk(4'b1101, 2'b11, 1'b0, 1'b0);
    out_request <= 4'hf;
    cyc(5);
    chk(4'b1101, 2'b11, 1'b0, 1'b0);
    $display("standard deadline tests done");
    // extended deadline, capacitive load on output 2
    boot(1'b1, 4'b0000, 1'b1, 4'b0000, 4'b0100);
    gap_chk(4'b1110);
    sync();
    stuck <= 4'b0100;
    out_request <= 4'b1011;
    cyc(45);
    chk(4'b1011, 2'b11, 1'b1, 1'b0);
    cyc(25);
    flt = 4'b0100;
    chk(4'b1011, 2'b11, 1'b0, 1'b0);
    $display("extended deadline tests done");
    // no plug write: the stored image must come back after reset
    boot(1'b0, 4'b1111, 1'b0, 4'b1111, 4'b0000);
    gap_chk(4'b1110);
    $display("plug retention test done");
    test_done();
  end
endmodule : safe_io_output_test_monitor_tb
